// [hdl/mbpm_pkg.sv]
// Constants and bundles shared by the memory bus pin multiplexer
package mbpm_pkg;
  localparam int ADDR_W = 12;
  // Offsets are register indices; the byte address is four times the index
  localparam logic [31:0] IDX_MGMT_FUNC = 32'hfffff04c;
  localparam logic [31:0] IDX_DRAM_FUNC = 32'hfffff04e;
  localparam logic [31:0] IDX_DMA_FUNC = 32'hfffff052;
  localparam logic [31:0] IDX_MGMT_DIR = 32'hfffff02c;
  localparam logic [ADDR_W-1:0] A_MGMT_FUNC = ADDR_W'(IDX_MGMT_FUNC * 32'h4);
  localparam logic [ADDR_W-1:0] A_DRAM_FUNC = ADDR_W'(IDX_DRAM_FUNC * 32'h4);
  localparam logic [ADDR_W-1:0] A_DMA_FUNC = ADDR_W'(IDX_DMA_FUNC * 32'h4);
  localparam logic [ADDR_W-1:0] A_MGMT_DIR = ADDR_W'(IDX_MGMT_DIR * 32'h4);
  localparam logic [ADDR_W-1:0] A_STROBE_SEL = 12'h200;
  localparam logic [ADDR_W-1:0] A_DRAM_DIR = 12'h204;
  localparam logic [ADDR_W-1:0] A_DMA_DIR = 12'h208;
  localparam logic [ADDR_W-1:0] A_MGMT_DATA = 12'h20c;
  localparam logic [ADDR_W-1:0] A_DRAM_DATA = 12'h210;
  localparam logic [ADDR_W-1:0] A_DMA_DATA = 12'h214;
  // Implemented bits per register
  localparam logic [7:0] M_MGMT = 8'h1f;
  localparam logic [7:0] M_DRAM = 8'h0f;
  localparam logic [7:0] M_STROBE = 8'h0c;
  localparam logic [7:0] M_DMA = 8'h03;
  // Reset values
  localparam logic [7:0] RST_MGMT_FUNC = 8'h1f;
  localparam logic [7:0] RST_DRAM_FUNC = 8'h0f;
  localparam logic [7:0] RST_STROBE = 8'h00;
  localparam logic [7:0] RST_DMA_FUNC = 8'h00;
  localparam logic [7:0] RST_DIR = 8'hff;
  localparam logic [7:0] RST_DATA = 8'h00;
  // Pin positions
  localparam int P_WAIT = 0;
  localparam int P_SYSCLK = 1;
  localparam int P_HOLD_ACK = 2;
  localparam int P_HOLD_REQ = 3;
  localparam int P_REFRESH = 4;
  localparam int P_CKE = 0;
  localparam int P_MCLK = 1;
  localparam int P_LOW = 2;
  localparam int P_UP = 3;

  typedef struct packed {
    logic [4:0] mgmt;
    logic [3:0] dram;
    logic [1:0] dma;
  } mbpm_pins_t;

  typedef struct packed {
    logic refresh_req;
    logic hold_ack;
    logic sys_clk;
    logic upper_be;
    logic lower_be;
    logic row_strobe;
    logic col_strobe;
    logic mem_clk;
    logic mem_cke;
    logic [1:0] dma_ack;
  } mbpm_ctl_t;
endpackage

// [hdl/mbpm_top.sv]
// Pin multiplexer for the memory control, DRAM and DMA acknowledge ports
//
// Notes on behaviour
// - Management bit 4 selects port I/O or refresh request output on pin 4.
// - Management bit 2 selects port I/O or hold acknowledge output on pin 2.
// - Management bit 1 selects port I/O or system clock output on pin 1.
// - Management bit 0 selects port I/O or wait input on pin 0.
// - Management select is byte or bit accessible, resets to 1fh.
// - DRAM port has four pins, each direction set alone in port mode.
// - DRAM bit 3 selects port I/O or upper byte enable / row strobe.
// - DRAM bit 2 selects port I/O or lower byte enable / column strobe.
// - DRAM bit 1 selects port I/O or memory clock output.
// - DRAM bit 0 selects port I/O or memory clock enable output.
// - DRAM select resets to 0fh, pins 3 and 2 as byte enables.
// - Strobe select bit 3 picks upper byte enable or row strobe.
// - Strobe select bit 2 picks lower byte enable or column strobe.
// - Strobe select bits 7..4, 1, 0 read zero, writes of one ignored.
// - In port mode the strobe select bit has no effect on the pin.
// - DMA port has two pins, outputs the two acknowledges in control mode.
// - DMA select bit picks port I/O or acknowledge, resets to 00h.
// - Direction 0 enables the output buffer, 1 makes the pin an input.
`timescale 1ns/10ps
module mbpm_top
  import mbpm_pkg::*;
(
  input wire logic clk,
  input wire logic reset_n,
  input wire logic [mbpm_pkg::ADDR_W-1:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [31:0] writedata,
  input wire logic [3:0] byteenable,
  output logic [31:0] readdata,
  output logic waitrequest,
  input wire mbpm_pkg::mbpm_ctl_t ctl_i,
  output logic wait_to_ctl,
  output logic hold_req_to_ctl,
  input wire mbpm_pkg::mbpm_pins_t pins_i,
  output mbpm_pkg::mbpm_pins_t pins_o,
  output mbpm_pkg::mbpm_pins_t pins_oe_n
);
  import mbpm_pkg::*;

  // ------------------------------------------------------------
  // Helpers
  // ------------------------------------------------------------
  function automatic logic [7:0] merge(input logic [7:0] old, input logic [7:0] wd,
                                       input logic [7:0] mask);
    merge = (wd & mask) | (old & ~mask);
  endfunction

  // Port mode output and enable: data latch gated by direction bit
  function automatic logic [1:0] port_pin(input logic func, input logic ctl_val,
                                          input logic is_in, input logic dat,
                                          input logic dir);
    if (func)
      port_pin = {ctl_val, is_in};
    else
      port_pin = {dat, dir};
  endfunction

  // ------------------------------------------------------------
  // Register state
  // ------------------------------------------------------------
  logic [7:0] mgmt_func_r, mgmt_func_nxt;
  logic [7:0] dram_func_r, dram_func_nxt;
  logic [7:0] strobe_r, strobe_nxt;
  logic [7:0] dma_func_r, dma_func_nxt;
  logic [7:0] mgmt_dir_r, mgmt_dir_nxt;
  logic [7:0] dram_dir_r, dram_dir_nxt;
  logic [7:0] dma_dir_r, dma_dir_nxt;
  logic [7:0] mgmt_dat_r, mgmt_dat_nxt;
  logic [7:0] dram_dat_r, dram_dat_nxt;
  logic [7:0] dma_dat_r, dma_dat_nxt;
  logic wait_r, wait_nxt;
  logic [31:0] rdata_r, rdata_nxt;
  logic wr_take;
  mbpm_pins_t sync1_r, sync2_r;

  // ------------------------------------------------------------
  // Bus slave
  // ------------------------------------------------------------
  // One wait cycle: request seen, answer on the next cycle
  assign wr_take = write && !wait_r && byteenable[0];

  always_comb
  begin
    wait_nxt = !((read || write) && wait_r);
    rdata_nxt = rdata_r;
    if (read && wait_r)
    begin
      case (address)
        A_MGMT_FUNC: rdata_nxt = {24'h0, mgmt_func_r & M_MGMT};
        A_DRAM_FUNC: rdata_nxt = {24'h0, dram_func_r & M_DRAM};
        A_STROBE_SEL: rdata_nxt = {24'h0, strobe_r & M_STROBE};
        A_DMA_FUNC: rdata_nxt = {24'h0, dma_func_r & M_DMA};
        A_MGMT_DIR: rdata_nxt = {24'h0, mgmt_dir_r & M_MGMT};
        A_DRAM_DIR: rdata_nxt = {24'h0, dram_dir_r & M_DRAM};
        A_DMA_DIR: rdata_nxt = {24'h0, dma_dir_r & M_DMA};
        // Data addresses read the synchronised pin level
        A_MGMT_DATA: rdata_nxt = {27'h0, sync2_r.mgmt};
        A_DRAM_DATA: rdata_nxt = {28'h0, sync2_r.dram};
        A_DMA_DATA: rdata_nxt = {30'h0, sync2_r.dma};
        default: rdata_nxt = 32'h0;
      endcase
    end
  end

  always_comb
  begin
    mgmt_func_nxt = mgmt_func_r;
    dram_func_nxt = dram_func_r;
    strobe_nxt = strobe_r;
    dma_func_nxt = dma_func_r;
    mgmt_dir_nxt = mgmt_dir_r;
    dram_dir_nxt = dram_dir_r;
    dma_dir_nxt = dma_dir_r;
    mgmt_dat_nxt = mgmt_dat_r;
    dram_dat_nxt = dram_dat_r;
    dma_dat_nxt = dma_dat_r;
    if (wr_take)
    begin
      case (address)
        A_MGMT_FUNC: mgmt_func_nxt = merge(mgmt_func_r, writedata[7:0], M_MGMT);
        A_DRAM_FUNC: dram_func_nxt = merge(dram_func_r, writedata[7:0], M_DRAM);
        A_STROBE_SEL: strobe_nxt = merge(strobe_r, writedata[7:0], M_STROBE);
        A_DMA_FUNC: dma_func_nxt = merge(dma_func_r, writedata[7:0], M_DMA);
        A_MGMT_DIR: mgmt_dir_nxt = merge(mgmt_dir_r, writedata[7:0], M_MGMT);
        A_DRAM_DIR: dram_dir_nxt = merge(dram_dir_r, writedata[7:0], M_DRAM);
        A_DMA_DIR: dma_dir_nxt = merge(dma_dir_r, writedata[7:0], M_DMA);
        A_MGMT_DATA: mgmt_dat_nxt = merge(mgmt_dat_r, writedata[7:0], M_MGMT);
        A_DRAM_DATA: dram_dat_nxt = merge(dram_dat_r, writedata[7:0], M_DRAM);
        A_DMA_DATA: dma_dat_nxt = merge(dma_dat_r, writedata[7:0], M_DMA);
        default: mgmt_func_nxt = mgmt_func_r;
      endcase
    end
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      mgmt_func_r <= RST_MGMT_FUNC;
      dram_func_r <= RST_DRAM_FUNC;
      strobe_r <= RST_STROBE;
      dma_func_r <= RST_DMA_FUNC;
      mgmt_dir_r <= RST_DIR & M_MGMT;
      dram_dir_r <= RST_DIR & M_DRAM;
      dma_dir_r <= RST_DIR & M_DMA;
      mgmt_dat_r <= RST_DATA;
      dram_dat_r <= RST_DATA;
      dma_dat_r <= RST_DATA;
      wait_r <= 1'b1;
      rdata_r <= 32'h0;
    end
    else
    begin
      mgmt_func_r <= mgmt_func_nxt;
      dram_func_r <= dram_func_nxt;
      strobe_r <= strobe_nxt;
      dma_func_r <= dma_func_nxt;
      mgmt_dir_r <= mgmt_dir_nxt;
      dram_dir_r <= dram_dir_nxt;
      dma_dir_r <= dma_dir_nxt;
      mgmt_dat_r <= mgmt_dat_nxt;
      dram_dat_r <= dram_dat_nxt;
      dma_dat_r <= dma_dat_nxt;
      wait_r <= wait_nxt;
      rdata_r <= rdata_nxt;
    end
  end

  assign waitrequest = wait_r;
  assign readdata = rdata_r;

  // ------------------------------------------------------------
  // Pin multiplexing
  // ------------------------------------------------------------
  mbpm_pins_t po_r, po_nxt, poe_r, poe_nxt;
  logic wait_ctl_r, wait_ctl_nxt, hreq_ctl_r, hreq_ctl_nxt;
  logic [1:0] up_sel, low_sel;

  always_comb
  begin
    // Strobe select only matters once the pin is in control mode
    up_sel = strobe_r[P_UP] ? {ctl_i.row_strobe, 1'b0} : {ctl_i.upper_be, 1'b0};
    low_sel = strobe_r[P_LOW] ? {ctl_i.col_strobe, 1'b0} : {ctl_i.lower_be, 1'b0};
    {po_nxt.mgmt[P_WAIT], poe_nxt.mgmt[P_WAIT]} = port_pin(mgmt_func_r[P_WAIT], 1'b0, 1'b1,
      mgmt_dat_r[P_WAIT], mgmt_dir_r[P_WAIT]);
    {po_nxt.mgmt[P_SYSCLK], poe_nxt.mgmt[P_SYSCLK]} = port_pin(mgmt_func_r[P_SYSCLK],
      ctl_i.sys_clk, 1'b0, mgmt_dat_r[P_SYSCLK], mgmt_dir_r[P_SYSCLK]);
    {po_nxt.mgmt[P_HOLD_ACK], poe_nxt.mgmt[P_HOLD_ACK]} = port_pin(mgmt_func_r[P_HOLD_ACK],
      ctl_i.hold_ack, 1'b0, mgmt_dat_r[P_HOLD_ACK], mgmt_dir_r[P_HOLD_ACK]);
    {po_nxt.mgmt[P_HOLD_REQ], poe_nxt.mgmt[P_HOLD_REQ]} = port_pin(mgmt_func_r[P_HOLD_REQ],
      1'b0, 1'b1, mgmt_dat_r[P_HOLD_REQ], mgmt_dir_r[P_HOLD_REQ]);
    {po_nxt.mgmt[P_REFRESH], poe_nxt.mgmt[P_REFRESH]} = port_pin(mgmt_func_r[P_REFRESH],
      ctl_i.refresh_req, 1'b0, mgmt_dat_r[P_REFRESH], mgmt_dir_r[P_REFRESH]);
    {po_nxt.dram[P_CKE], poe_nxt.dram[P_CKE]} = port_pin(dram_func_r[P_CKE],
      ctl_i.mem_cke, 1'b0, dram_dat_r[P_CKE], dram_dir_r[P_CKE]);
    {po_nxt.dram[P_MCLK], poe_nxt.dram[P_MCLK]} = port_pin(dram_func_r[P_MCLK],
      ctl_i.mem_clk, 1'b0, dram_dat_r[P_MCLK], dram_dir_r[P_MCLK]);
    {po_nxt.dram[P_LOW], poe_nxt.dram[P_LOW]} = port_pin(dram_func_r[P_LOW], low_sel[1],
      low_sel[0], dram_dat_r[P_LOW], dram_dir_r[P_LOW]);
    {po_nxt.dram[P_UP], poe_nxt.dram[P_UP]} = port_pin(dram_func_r[P_UP], up_sel[1],
      up_sel[0], dram_dat_r[P_UP], dram_dir_r[P_UP]);
    for (int i = 0; i < 2; i++)
    begin
      {po_nxt.dma[i], poe_nxt.dma[i]} = port_pin(dma_func_r[i], ctl_i.dma_ack[i], 1'b0,
        dma_dat_r[i], dma_dir_r[i]);
    end
    // Inputs to the controller rest low while their pin is in port mode
    wait_ctl_nxt = mgmt_func_r[P_WAIT] & sync2_r.mgmt[P_WAIT];
    hreq_ctl_nxt = mgmt_func_r[P_HOLD_REQ] & sync2_r.mgmt[P_HOLD_REQ];
  end

  always_ff @(posedge clk or negedge reset_n)
  begin
    if (!reset_n)
    begin
      sync1_r <= '0;
      sync2_r <= '0;
      po_r <= '0;
      // Drivers stay off until the first clocked update
      poe_r <= '1;
      wait_ctl_r <= 1'b0;
      hreq_ctl_r <= 1'b0;
    end
    else
    begin
      sync1_r <= pins_i;
      sync2_r <= sync1_r;
      po_r <= po_nxt;
      poe_r <= poe_nxt;
      wait_ctl_r <= wait_ctl_nxt;
      hreq_ctl_r <= hreq_ctl_nxt;
    end
  end

  assign pins_o = po_r;
  assign pins_oe_n = poe_r;
  assign wait_to_ctl = wait_ctl_r;
  assign hold_req_to_ctl = hreq_ctl_r;

  // ------------------------------------------------------------
  // Assertions
  // ------------------------------------------------------------
  sequence s_wr(logic [ADDR_W-1:0] a);
    write && !wait_r && byteenable[0] && address == a;
  endsequence

  sequence s_rd_req;
    read && wait_r;
  endsequence

  a_refresh_pin_drive: assert property (@(posedge clk) disable iff (!reset_n)
    reset_n && mgmt_func_r[P_REFRESH] |=> pins_o.mgmt[P_REFRESH] == $past(ctl_i.refresh_req)
      && !pins_oe_n.mgmt[P_REFRESH])
    else $error("refresh pin not driven by controller");

  a_hold_ack_drive: assert property (@(posedge clk) disable iff (!reset_n)
    !mgmt_func_r[P_HOLD_ACK] |=> pins_o.mgmt[P_HOLD_ACK] == $past(mgmt_dat_r[P_HOLD_ACK])
      && pins_oe_n.mgmt[P_HOLD_ACK] == $past(mgmt_dir_r[P_HOLD_ACK]))
    else $error("hold ack pin port mode wrong");

  a_sysclk_pin_drive: assert property (@(posedge clk) disable iff (!reset_n)
    mgmt_func_r[P_SYSCLK] |=> pins_o.mgmt[P_SYSCLK] == $past(ctl_i.sys_clk))
    else $error("clock pin not carrying system clock");

  a_wait_input_gate: assert property (@(posedge clk) disable iff (!reset_n)
    !mgmt_func_r[P_WAIT] |=> !wait_to_ctl && pins_oe_n.mgmt[P_WAIT] == $past(mgmt_dir_r[P_WAIT]))
    else $error("wait input leaks in port mode");

  a_hold_req_path: assert property (@(posedge clk) disable iff (!reset_n)
    mgmt_func_r[P_HOLD_REQ] && pins_i.mgmt[P_HOLD_REQ] && mgmt_func_nxt[P_HOLD_REQ]
      ##1 mgmt_func_r[P_HOLD_REQ] && pins_i.mgmt[P_HOLD_REQ] && mgmt_func_nxt[P_HOLD_REQ]
      |-> ##2 hold_req_to_ctl && pins_oe_n.mgmt[P_HOLD_REQ])
    else $error("hold request not passed after sync");

  a_strobe_select_up: assert property (@(posedge clk) disable iff (!reset_n)
    dram_func_r[P_UP] && strobe_r[P_UP] |=> pins_o.dram[P_UP] == $past(ctl_i.row_strobe))
    else $error("row strobe not on pin 3");

  a_strobe_port_mode: assert property (@(posedge clk) disable iff (!reset_n)
    !dram_func_r[P_LOW] |=> pins_o.dram[P_LOW] == $past(dram_dat_r[P_LOW]))
    else $error("strobe select affects port mode pin");

  a_strobe_fixed_bits: assert property (@(posedge clk) disable iff (!reset_n)
    s_wr(A_STROBE_SEL) |=> (strobe_r & ~M_STROBE) == 8'h00
      && strobe_r[P_UP] == $past(writedata[P_UP]))
    else $error("strobe select fixed bits changed");

  a_dma_ack_drive: assert property (@(posedge clk) disable iff (!reset_n)
    dma_func_r[1] |=> pins_o.dma[1] == $past(ctl_i.dma_ack[1]) && !pins_oe_n.dma[1])
    else $error("dma ack not driven");

  a_mgmt_write_read: assert property (@(posedge clk) disable iff (!reset_n)
    s_wr(A_MGMT_FUNC) ##2 (s_rd_req and address == A_MGMT_FUNC) |=>
      readdata[7:0] == ($past(writedata[7:0], 3) & M_MGMT) && !waitrequest)
    else $error("management select readback wrong");
endmodule

// [testbench/mbpm_pin_model.sv]
// Far-side model: external memory and hold requester on the multiplexed pins
`timescale 1ns/10ps
module mbpm_pin_model
  import mbpm_pkg::*;
(
  input wire mbpm_pkg::mbpm_pins_t pins_o,
  input wire mbpm_pkg::mbpm_pins_t pins_oe_n,
  input wire mbpm_pkg::mbpm_pins_t ext,
  output mbpm_pkg::mbpm_pins_t pins_i
);
  // ----------------------------------------
  // Wire level
  // ----------------------------------------
  // Block wins where it drives; elsewhere the far side drives wait, hold request and inputs
  always_comb
  begin
    for (int i = 0; i < $bits(mbpm_pins_t); i++)
      pins_i[i] = pins_oe_n[i] ? ext[i] : pins_o[i];
  end
endmodule

// [testbench/tb_memory_bus_pin_mux.sv]
// Self-checking bench for the memory bus pin multiplexer
`timescale 1ns/10ps
module tb_memory_bus_pin_mux;
  import mbpm_pkg::*;
  logic clk;
  logic reset_n;
  logic [ADDR_W-1:0] address;
  logic read;
  logic write;
  logic [31:0] writedata;
  logic [3:0] byteenable;
  logic [31:0] readdata;
  logic waitrequest;
  mbpm_ctl_t ctl_i;
  logic wait_to_ctl;
  logic hold_req_to_ctl;
  mbpm_pins_t pins_i;
  mbpm_pins_t pins_o;
  mbpm_pins_t pins_oe_n;
  mbpm_pins_t ext;
  mbpm_pins_t exp_o;
  logic [31:0] rd;
  int err_count;
  int n_tests;

  mbpm_top i_dut (.clk(clk), .reset_n(reset_n), .address(address), .read(read),
    .write(write), .writedata(writedata), .byteenable(byteenable), .readdata(readdata),
    .waitrequest(waitrequest), .ctl_i(ctl_i), .wait_to_ctl(wait_to_ctl),
    .hold_req_to_ctl(hold_req_to_ctl), .pins_i(pins_i), .pins_o(pins_o),
    .pins_oe_n(pins_oe_n));
  mbpm_pin_model i_far (.pins_o(pins_o), .pins_oe_n(pins_oe_n), .ext(ext), .pins_i(pins_i));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_tests++;
    if (got !== exp)
    begin
      err_count++;
      $display("FAIL %0t %s got %h exp %h", $time, what, got, exp);
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", n_tests, err_count);
    if (err_count == 0 && n_tests > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  // Registered outputs read right after the edge still show the pre-edge value
  task automatic bus(input logic wr, input logic [ADDR_W-1:0] a, input logic [31:0] d,
                     input logic [3:0] be);
    int n;
    n = 0;
    @(posedge clk);
    address <= a;
    read <= !wr;
    write <= wr;
    writedata <= d;
    byteenable <= be;
    do
    begin
      @(posedge clk);
      n++;
    end
    while (waitrequest !== 1'b0 && n < 50);
    rd = readdata;
    read <= 1'b0;
    write <= 1'b0;
    if (n >= 50)
      chk(0, 1, "bus hang");
  endtask

  task automatic wr(input logic [ADDR_W-1:0] a, input logic [31:0] d);
    bus(1'b1, a, d, 4'h1);
  endtask

  task automatic rdc(input logic [ADDR_W-1:0] a, input logic [31:0] exp, input string what);
    bus(1'b0, a, 32'h0, 4'h0);
    chk(rd, exp, what);
  endtask

  task automatic settle();
    repeat (4) @(posedge clk);
  endtask

  // Every controller signal toggles between the two patterns
  task automatic ctl_run(input logic rc, input logic [1:0] dma_on);
    for (int k = 0; k < 2; k++)
    begin
      ctl_i <= k ? mbpm_ctl_t'(11'h5a5) : mbpm_ctl_t'(11'h25a);
      settle();
      exp_o.mgmt = {ctl_i.refresh_req, 1'b0, ctl_i.hold_ack, ctl_i.sys_clk, 1'b0};
      exp_o.dram[1:0] = {ctl_i.mem_clk, ctl_i.mem_cke};
      exp_o.dram[3:2] = rc ? {ctl_i.row_strobe, ctl_i.col_strobe} :
                             {ctl_i.upper_be, ctl_i.lower_be};
      exp_o.dma = dma_on & ctl_i.dma_ack;
      chk(pins_o, exp_o, "ctl pins");
      chk(pins_oe_n, {5'h09, 4'h0, ~dma_on}, "ctl oe");
    end
  endtask

  // ----------------------------------------
  // Sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end

  initial
  begin
    repeat (20000) @(posedge clk);
    err_count++;
    end_of_test();
  end

  initial
  begin
    reset_n = 1'b0;
    address = '0;
    read = 1'b0;
    write = 1'b0;
    writedata = '0;
    byteenable = '0;
    ctl_i = '0;
    ext = '0;
    exp_o = '0;
    err_count = 0;
    n_tests = 0;
    repeat (16) @(posedge clk);
    reset_n <= 1'b1;
    rdc(A_MGMT_FUNC, 32'h1f, "mgmt func");
    rdc(A_DRAM_FUNC, 32'h0f, "dram func");
    rdc(A_STROBE_SEL, 32'h00, "strobe");
    rdc(A_DMA_FUNC, 32'h00, "dma func");
    rdc(12'h300, 32'h00, "unmapped");
    ctl_run(1'b0, 2'b00);
    // Strobes must be chosen before SDRAM use; fixed bits must stay zero
    wr(A_STROBE_SEL, 32'hff);
    rdc(A_STROBE_SEL, 32'h0c, "strobe fixed");
    ctl_run(1'b1, 2'b00);
    bus(1'b1, A_DMA_FUNC, 32'h03, 4'h0);
    rdc(A_DMA_FUNC, 32'h00, "lane off");
    wr(A_DMA_FUNC, 32'h03);
    ctl_run(1'b1, 2'b11);
    ext <= mbpm_pins_t'({5'h09, 6'h00});
    settle();
    chk(wait_to_ctl, 1'b1, "wait in");
    chk(hold_req_to_ctl, 1'b1, "hold in");
    wr(A_MGMT_FUNC, 32'h00);
    settle();
    chk(wait_to_ctl, 1'b0, "wait port");
    chk(hold_req_to_ctl, 1'b0, "hold port");
    chk(pins_oe_n.mgmt, 5'h1f, "mgmt released");
    wr(A_MGMT_DIR, 32'h00);
    wr(A_MGMT_DATA, 32'h15);
    settle();
    chk(pins_o.mgmt, 5'h15, "mgmt latch");
    chk(pins_oe_n.mgmt, 5'h00, "mgmt driven");
    rdc(A_MGMT_DIR, 32'h00, "mgmt dir rd");
    rdc(A_MGMT_DATA, 32'h15, "mgmt pins rd");
    // Clock divider is assumed at unity here; a switch at another ratio may glitch
    wr(A_MGMT_FUNC, 32'h02);
    rdc(A_MGMT_FUNC, 32'h02, "mgmt func rd");
    settle();
    chk(pins_o.mgmt, {3'h5, ctl_i.sys_clk, 1'b1}, "clock back");
    wr(A_DRAM_FUNC, 32'h00);
    wr(A_DRAM_DIR, 32'h05);
    wr(A_DRAM_DATA, 32'h0f);
    settle();
    chk(pins_oe_n.dram, 4'h5, "dram dir");
    chk(pins_o.dram, 4'hf, "dram latch");
    rdc(A_DRAM_DIR, 32'h05, "dram dir rd");
    // Inputs 0 and 2 see the far side low, outputs 1 and 3 drive high
    rdc(A_DRAM_DATA, 32'h0a, "dram pins rd");
    // Memory clock first, its enable in a later write
    wr(A_DRAM_FUNC, 32'h02);
    wr(A_DRAM_FUNC, 32'h03);
    settle();
    chk(pins_o.dram, {2'h3, ctl_i.mem_clk, ctl_i.mem_cke}, "clk pins");
    chk(pins_oe_n.dram, 4'h4, "clk oe");
    wr(A_DMA_FUNC, 32'h00);
    wr(A_DMA_DIR, 32'h02);
    settle();
    chk(pins_oe_n.dma, 2'h2, "dma dir");
    rdc(A_DMA_DIR, 32'h02, "dma dir rd");
    end_of_test();
  end
endmodule
